/* File: design/asrx_map.svh */
/*
  Constants for the asynchronous receive front end: oversampling thresholds,
  field positions and widths, all as macros.
  Assumes it is included by bare name from the design files.
*/
`ifndef ASRX_MAP_SVH
`define ASRX_MAP_SVH

`define ASRX_X16_REJECT_LT   8'h07
`define ASRX_X64_REJECT_LT   8'h1f
`define ASRX_X16_ACCEPT_MIN  8'h09
`define ASRX_X64_ACCEPT_MIN  8'h21
`define ASRX_X16_FULL_BIT    8'h10
`define ASRX_X64_FULL_BIT    8'h40
`define ASRX_X16_HALF_BIT    8'h08
`define ASRX_X64_HALF_BIT    8'h20
`define ASRX_FIFO_DEPTH      8
`define ASRX_DATA_BITS       8
`define ASRX_WORD_PERR_BIT   8
`define ASRX_WORD_FERR_BIT   9
`define ASRX_WORD_WIDTH      10

`endif

/* File: design/asrx_pkg.sv */
/*
  Types shared by the receive front end.
  Assumes asrx_map.svh supplies the numeric constants.
*/
package asrx_pkg;
  typedef enum logic [1:0] {
    ASRX_IDLE,
    ASRX_START,
    ASRX_DATA,
    ASRX_STOP
  } asrx_state_t;
  typedef enum logic [1:0] {
    ASRX_PAR_NONE,
    ASRX_PAR_ODD,
    ASRX_PAR_EVEN
  } asrx_par_t;
endpackage : asrx_pkg

/* File: design/asrx_fifo.sv */
/*
  Synchronous FIFO with registered read data and valid/ready on both sides.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module asrx_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  input  wire logic             mclk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] wr_data_i,
  input  wire logic             wr_valid_i,
  output logic                  wr_ready_o,
  output logic      [WIDTH-1:0] rd_data_o,
  output logic                  rd_valid_o,
  input  wire logic             rd_ready_i
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("asrx_fifo: DEPTH must be a power of two >= 2");
  end

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0]      wp_r, wp_nxt, rp_r, rp_nxt;
  logic [WIDTH-1:0] out_r, out_nxt;
  logic             ov_r, ov_nxt;
  logic             do_wr, do_pop, empty;

  // A word is moved to the output register whenever it is empty or being taken.
  assign empty      = (wp_r == rp_r);
  assign wr_ready_o = !((wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]));
  assign do_wr      = wr_valid_i && wr_ready_o;
  assign do_pop     = !empty && (!ov_r || rd_ready_i);
  assign rd_data_o  = out_r;
  assign rd_valid_o = ov_r;

  // Pointer and output stage next values.
  always_comb begin
    wp_nxt  = do_wr ? wp_r + 1'b1 : wp_r;
    rp_nxt  = do_pop ? rp_r + 1'b1 : rp_r;
    out_nxt = do_pop ? mem_r[rp_r[AW-1:0]] : out_r;
    ov_nxt  = do_pop ? 1'b1 : (rd_ready_i ? 1'b0 : ov_r);
  end

  // Storage has no reset; only pointers and valid need one.
  always_ff @(posedge mclk_i) begin
    if (do_wr) mem_r[wp_r[AW-1:0]] <= wr_data_i;
    if (rst_i) begin
      wp_r  <= '0;
      rp_r  <= '0;
      out_r <= '0;
      ov_r  <= 1'b0;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      out_r <= out_nxt;
      ov_r  <= ov_nxt;
    end
  end
endmodule : asrx_fifo

/* File: design/asrx_front.sv */
/*
  Asynchronous receive front end: start bit validation at 16x or 64x
  oversampling, character assembly, parity and break handling, and a FIFO
  of received words toward the host side.
  Assumes rx_serial_i and rx_sample_clock_i are already synchronous to mclk_i;
  one oversampling period is one rising edge of rx_sample_clock_i.
  A break is a frame whose data, parity and stop slots were all low; the
  receiver keeps assembling frames while the line stays low, so a break end
  can land in any slot of a frame that started inside the break.
*/
// Contract
// - At 16x, a low pulse under 7 sample periods is discarded.
// - At 64x, a low pulse under 31 sample periods is discarded.
// - At 16x, low lasting 9 to 16 periods is a valid start bit.
// - At 64x, low lasting 33 to 64 periods is a valid start bit.
// - Exactly 8 or 32 periods is handled deterministically, never mid-frame ready.
// - Break ending between last data bit and parity sets the parity error flag.
// - In that break-end case no character-ready is given for the frame.
// - That parity flag stays set through the next normal character.
`timescale 1ns/1ps
`include "asrx_map.svh"
module asrx_front #(
  parameter int FIFO_DEPTH = `ASRX_FIFO_DEPTH
) (
  input  wire logic                        mclk_i,
  input  wire logic                        rst_i,
  input  wire logic                        rx_sample_clock_i,
  input  wire logic                        rx_serial_i,
  input  wire logic                        mode_x64_i,
  input  wire logic [1:0]                  parity_mode_i,
  input  wire logic                        perr_clear_i,
  output logic                             char_valid_o,
  input  wire logic                        char_ready_i,
  output logic [`ASRX_WORD_WIDTH-1:0]      char_word_o,
  output logic                             parity_err_o,
  output logic                             overrun_o,
  output logic                             break_o
);
  initial begin
    if (FIFO_DEPTH < 2) $error("asrx_front: FIFO_DEPTH too small");
  end

  asrx_pkg::asrx_state_t                st_r, st_nxt;
  logic                                 clk_d_r, clk_d_nxt;
  logic                                 tick;
  logic [7:0]                           cnt_r, cnt_nxt;
  logic [3:0]                           bit_r, bit_nxt;
  logic [`ASRX_DATA_BITS-1:0]           sh_r, sh_nxt;
  logic                                 par_bit_r, par_bit_nxt;
  logic                                 brk_r, brk_nxt;
  // Set once a whole frame was seen low, so that a plain all-zero character
  // with a high parity bit is not mistaken for the end of a break unless the break ended before the next start bit was accepted.
  logic                                 brk_seen_r, brk_seen_nxt;
  logic                                 perr_r, perr_nxt;
  logic                                 ovr_r, ovr_nxt;
  logic                                 push;
  logic [`ASRX_WORD_WIDTH-1:0]          push_word;
  logic                                 fifo_wr_ready;
  logic [7:0]                           half_cnt, full_cnt;
  logic                                 has_par, calc_par;

  // Edge of the oversampling clock acts as one sample period.
  assign tick      = rx_sample_clock_i && !clk_d_r;
  assign clk_d_nxt = rx_sample_clock_i;
  // Midpoint checks land on 8 or 32 periods, so a pulse of 8 or 32 low is
  // still low at the check and is accepted as a whole start bit every time.
  assign half_cnt  = mode_x64_i ? `ASRX_X64_HALF_BIT : `ASRX_X16_HALF_BIT;
  assign full_cnt  = mode_x64_i ? `ASRX_X64_FULL_BIT : `ASRX_X16_FULL_BIT;
  assign has_par   = (parity_mode_i != 2'(asrx_pkg::ASRX_PAR_NONE));
  assign calc_par  = (^sh_r) ^ (parity_mode_i == 2'(asrx_pkg::ASRX_PAR_ODD));

  // Receive sequence: start check, data bits, optional parity, stop.
  always_comb begin
    st_nxt      = st_r;
    cnt_nxt     = cnt_r;
    bit_nxt     = bit_r;
    sh_nxt      = sh_r;
    par_bit_nxt = par_bit_r;
    brk_nxt     = brk_r;
    brk_seen_nxt = brk_seen_r;
    perr_nxt    = perr_clear_i ? 1'b0 : perr_r;
    ovr_nxt     = ovr_r;
    push        = 1'b0;
    push_word   = {perr_r, sh_r, 1'b0} >> 1;
    case (st_r)
      asrx_pkg::ASRX_IDLE: begin
        cnt_nxt = '0;
        if (tick && !rx_serial_i) begin
          st_nxt  = asrx_pkg::ASRX_START;
          cnt_nxt = 8'h01;
        end
      end
      asrx_pkg::ASRX_START: begin
        if (tick) begin
          // Short pulses return high before the midpoint and are dropped.
          if (rx_serial_i) begin
            st_nxt = asrx_pkg::ASRX_IDLE;
          end else if (cnt_r == half_cnt - 8'h01) begin
            // Line still low at the midpoint: a start bit is accepted.
            st_nxt  = asrx_pkg::ASRX_DATA;
            cnt_nxt = '0;
            bit_nxt = '0;
            brk_nxt = 1'b1;
          end else begin
            cnt_nxt = cnt_r + 8'h01;
          end
        end
      end
      asrx_pkg::ASRX_DATA: begin
        if (tick) begin
          cnt_nxt = cnt_r + 8'h01;
          if (cnt_r == full_cnt - 8'h01) begin
            cnt_nxt = '0;
            brk_nxt = brk_r && !rx_serial_i;
            if (bit_r < 4'(`ASRX_DATA_BITS)) begin
              sh_nxt = {rx_serial_i, sh_r[`ASRX_DATA_BITS-1:1]};
              if (bit_r == 4'(`ASRX_DATA_BITS) - 4'h1 && !has_par) st_nxt = asrx_pkg::ASRX_STOP;
            end else begin
              par_bit_nxt = rx_serial_i;
              st_nxt      = asrx_pkg::ASRX_STOP;
              // Line rose at the parity slot after an all-low frame: break ended.
              if (brk_seen_r && brk_r && rx_serial_i) begin
                perr_nxt     = 1'b1;
                brk_seen_nxt = 1'b0;
                st_nxt   = asrx_pkg::ASRX_IDLE;
              end else if (rx_serial_i != calc_par) begin
                perr_nxt = 1'b1;
              end
            end
            bit_nxt = bit_r + 4'h1;
          end
        end
      end
      asrx_pkg::ASRX_STOP: begin
        if (tick) begin
          cnt_nxt = cnt_r + 8'h01;
          if (cnt_r == full_cnt - 8'h01) begin
            st_nxt = asrx_pkg::ASRX_IDLE;
            if (brk_r && !rx_serial_i) begin
              brk_nxt      = 1'b1;
              brk_seen_nxt = 1'b1;
            end else begin
              brk_nxt      = 1'b0;
              brk_seen_nxt = 1'b0;
              // Flag is sticky: it stays in the word until cleared.
              push      = 1'b1;
              push_word = {!rx_serial_i, perr_nxt, sh_r};
              if (!fifo_wr_ready) ovr_nxt = 1'b1;
            end
          end
        end
      end
      default: st_nxt = asrx_pkg::ASRX_IDLE;
    endcase
    if (perr_clear_i && push) perr_nxt = perr_nxt; // No effect; a parity-slot set in DATA overrides a clear in the same cycle.
  end

  // Registers only.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      st_r      <= asrx_pkg::ASRX_IDLE;
      clk_d_r   <= 1'b0;
      cnt_r     <= '0;
      bit_r     <= '0;
      sh_r      <= '0;
      par_bit_r <= 1'b0;
      brk_r     <= 1'b0;
      brk_seen_r <= 1'b0;
      perr_r    <= 1'b0;
      ovr_r     <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      clk_d_r   <= clk_d_nxt;
      cnt_r     <= cnt_nxt;
      bit_r     <= bit_nxt;
      sh_r      <= sh_nxt;
      par_bit_r <= par_bit_nxt;
      brk_r     <= brk_nxt;
      brk_seen_r <= brk_seen_nxt;
      perr_r    <= perr_nxt;
      ovr_r     <= ovr_nxt;
    end
  end

  assign parity_err_o = perr_r;
  assign overrun_o    = ovr_r;
  assign break_o      = brk_r && (st_r == asrx_pkg::ASRX_STOP);

  // A full FIFO drops the word and raises overrun rather than stalling the line.
  asrx_fifo #(
    .WIDTH (`ASRX_WORD_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk_i     (mclk_i),
    .rst_i      (rst_i),
    .wr_data_i  (push_word),
    .wr_valid_i (push),
    .wr_ready_o (fifo_wr_ready),
    .rd_data_o  (char_word_o),
    .rd_valid_o (char_valid_o),
    .rd_ready_i (char_ready_i)
  );
endmodule : asrx_front

/* File: verification/asrx_front_sva.sv */
/* Port checker for asrx_front.
   Assumes one clock and a synchronous active-high reset; bound below. */
`timescale 1ns/1ps
`include "asrx_map.svh"
module asrx_front_sva (
  input wire logic                   mclk_i,
  input wire logic                   rst_i,
  input wire logic                   rx_sample_clock_i,
  input wire logic                   rx_serial_i,
  input wire logic                   mode_x64_i,
  input wire logic [1:0]             parity_mode_i,
  input wire logic                   perr_clear_i,
  input wire logic                   char_valid_o,
  input wire logic                   char_ready_i,
  input wire logic [`ASRX_WORD_WIDTH-1:0] char_word_o,
  input wire logic                   parity_err_o,
  input wire logic                   overrun_o,
  input wire logic                   break_o
);
  logic        sclk_r;
  logic [7:0]  run_r;
  logic [15:0] starts_r;
  logic [15:0] pops_r;
  wire         period = rx_sample_clock_i && !sclk_r;
  // A low run reaching half a bit is the only thing allowed to start a word; data zeros only loosen the bound.
  always_ff @(posedge mclk_i) begin
    sclk_r <= rx_sample_clock_i;
    if (rst_i) begin
      run_r <= 8'h00;
      starts_r <= 16'h0000;
      pops_r <= 16'h0000;
    end else begin
      if (period) run_r <= rx_serial_i ? 8'h00 : run_r + 8'h01;
      if (period && !rx_serial_i && run_r == (mode_x64_i ? `ASRX_X64_REJECT_LT : `ASRX_X16_REJECT_LT))
        starts_r <= starts_r + 16'h0001;
      if (char_valid_o && char_ready_i) pops_r <= pops_r + 16'h0001;
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // Outputs stay quiet through and right after reset.
  AST_RESET_QUIET: assert property (disable iff (1'b0)
    rst_i |=> !char_valid_o && !parity_err_o && !overrun_o && !break_o) else $error("output active after reset");
  AST_WORDS_NEED_START: assert property (
    pops_r <= starts_r) else $error("word delivered without a valid start");
  AST_WORD_HOLD: assert property (
    char_valid_o && !char_ready_i |=> char_valid_o && $stable(char_word_o)) else $error("word dropped while stalled");
  AST_PERR_STICKY: assert property (
    parity_err_o && !perr_clear_i |=> parity_err_o) else $error("parity flag lost");
  AST_PERR_FELL: assert property (
    $fell(parity_err_o) |-> $past(perr_clear_i)) else $error("parity flag cleared without request");
  AST_PERR_RISE: assert property (
    $rose(parity_err_o) |-> parity_mode_i != 2'h0) else $error("parity flag with parity off");
  AST_OVR_STICKY: assert property (
    overrun_o |=> overrun_o) else $error("overrun flag lost");
  AST_OVR_CAUSE: assert property (
    $rose(overrun_o) |-> $past(char_valid_o) && !$past(char_ready_i)) else $error("overrun while not full");
endmodule : asrx_front_sva
bind asrx_front asrx_front_sva u_sva (.mclk_i(mclk_i), .rst_i(rst_i), .rx_sample_clock_i(rx_sample_clock_i),
  .rx_serial_i(rx_serial_i), .mode_x64_i(mode_x64_i), .parity_mode_i(parity_mode_i), .perr_clear_i(perr_clear_i),
  .char_valid_o(char_valid_o), .char_ready_i(char_ready_i), .char_word_o(char_word_o),
  .parity_err_o(parity_err_o), .overrun_o(overrun_o), .break_o(break_o));

/* File: verification/asrx_tx_model.sv */
/* Remote transmitter model: free-running sample clock and serial line.
   Assumes callers enter tasks just after a clock edge. */
`timescale 1ns/1ps
module asrx_tx_model (
  input  wire logic mclk_i,
  output logic      sclk_o,
  output logic      line_o
);
  int ph = 0;
  initial begin
    sclk_o = 1'b0;
    line_o = 1'b1;
  end
  // One sample period is four cycles, two high and two low.
  always @(posedge mclk_i) begin
    #1 ph = (ph + 1) % 4;
    sclk_o = (ph < 2);
  end
  // The line moves right after a sampling edge, so n sampling edges see v.
  task automatic hold(input logic v, input int n);
    line_o = v;
    repeat (n) begin
      @(posedge sclk_o);
      @(posedge mclk_i);
      #1;
    end
  endtask : hold
  task automatic pulse(input int n, input int rest);
    hold(1'b1, 1);
    hold(1'b0, n);
    hold(1'b1, rest);
  endtask : pulse
  task automatic frame(input logic [7:0] d, input logic [1:0] pm, input int m);
    hold(1'b1, 1);
    hold(1'b0, m);
    for (int i = 0; i < 8; i++) hold(d[i], m);
    if (pm != 2'h0) hold(^d ^ (pm == 2'h1), m);
    hold(1'b1, 2 * m);
  endtask : frame
endmodule : asrx_tx_model

/* File: verification/async_rx_start_break_check_tb.sv */
/* Self-checking bench for asrx_front.
   Assumes the line model drives the serial side; this bench is the consumer. */
`timescale 1ns/1ps
module async_rx_start_break_check_tb;
  typedef struct {logic [7:0] d; logic [1:0] pm; int m; logic [9:0] w;} asrx_row_t;
  asrx_row_t rows [5] = '{'{8'h55, 2'h0, 16, 10'h055}, '{8'h00, 2'h1, 16, 10'h000},
    '{8'hff, 2'h2, 16, 10'h0ff}, '{8'ha3, 2'h1, 64, 10'h0a3}, '{8'h01, 2'h2, 64, 10'h001}};
  int          lens [4] = '{6, 7, 30, 31};
  int          half [2] = '{8, 32};
  logic        mclk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        mode_x64_i = 1'b0;
  logic [1:0]  parity_mode_i = 2'h0;
  logic        perr_clear_i = 1'b0;
  logic        char_ready_i = 1'b0;
  logic        char_valid_o, parity_err_o, overrun_o, break_o, sclk, line;
  logic [9:0]  char_word_o;
  int          n_errors = 0;
  int          num_checks = 0;
  logic        brk_hit = 1'b0;
  // Remembers that the break output was shown at least once.
  always @(posedge mclk_i) if (break_o === 1'b1) brk_hit <= 1'b1;
  initial forever #5 mclk_i = ~mclk_i;
  asrx_tx_model TX (.mclk_i(mclk_i), .sclk_o(sclk), .line_o(line));
  asrx_front #(.FIFO_DEPTH(8)) DUT (.mclk_i(mclk_i), .rst_i(rst_i), .rx_sample_clock_i(sclk),
    .rx_serial_i(line), .mode_x64_i(mode_x64_i), .parity_mode_i(parity_mode_i), .perr_clear_i(perr_clear_i),
    .char_valid_o(char_valid_o), .char_ready_i(char_ready_i), .char_word_o(char_word_o),
    .parity_err_o(parity_err_o), .overrun_o(overrun_o), .break_o(break_o));
  task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Waits a bounded time for a word, compares it, then takes it.
  task automatic take(input logic [9:0] w);
    int n;
    n = 0;
    while (char_valid_o !== 1'b1 && n < 5000) begin
      @(posedge mclk_i);
      #1 n++;
    end
    chk("valid", 10'h001, {9'h000, char_valid_o});
    chk("word", w, char_word_o);
    char_ready_i = 1'b1;
    @(posedge mclk_i);
    #1 char_ready_i = 1'b0;
  endtask : take
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report
  // The whole run needs about 32k cycles, so 60k leaves margin.
  initial begin
    #600000 n_errors++;
    final_report();
  end
  initial begin
    repeat (2) @(posedge mclk_i);
    #1 rst_i = 1'b0;
    chk("reset", 10'h000, {6'h00, char_valid_o, parity_err_o, overrun_o, break_o});
    foreach (rows[i]) begin
      mode_x64_i = (rows[i].m == 64);
      parity_mode_i = rows[i].pm;
      TX.frame(rows[i].d, rows[i].pm, rows[i].m);
      take(rows[i].w);
    end
    parity_mode_i = 2'h0;
    foreach (lens[i]) begin
      mode_x64_i = (lens[i] > 8);
      TX.pulse(lens[i], lens[i] * 32);
      chk("short", 10'h000, {9'h000, char_valid_o});
    end
    // The half-bit boundary is accepted, giving an all-ones word.
    foreach (half[i]) begin
      mode_x64_i = (half[i] == 32);
      TX.pulse(half[i], half[i] * 24);
      take(10'h0ff);
    end
    mode_x64_i = 1'b0;
    // Even parity keeps the first all-low frame free of parity errors; the line
    // rises between the last data bit and parity of the second frame.
    parity_mode_i = 2'h2;
    TX.pulse(312, 48);
    chk("break", 10'h001, {9'h000, brk_hit});
    chk("perr", 10'h001, {9'h000, parity_err_o});
    chk("brk_valid", 10'h000, {9'h000, char_valid_o});
    TX.frame(8'h3c, 2'h2, 16);
    take(10'h13c);
    chk("perr_kept", 10'h001, {9'h000, parity_err_o});
    perr_clear_i = 1'b1;
    @(posedge mclk_i);
    #1 perr_clear_i = 1'b0;
    chk("perr_clr", 10'h000, {9'h000, parity_err_o});
    parity_mode_i = 2'h0;
    // Eight stored words plus the output register hold nine; the tenth overruns.
    for (int i = 0; i < 10; i++) TX.frame(8'(i), 2'h0, 16);
    chk("overrun", 10'h001, {9'h000, overrun_o});
    for (int i = 0; i < 9; i++) take(10'(i));
    chk("empty", 10'h000, {9'h000, char_valid_o});
    final_report();
  end
endmodule : async_rx_start_break_check_tb
